// ==== ipd_top.sv ====
// Purpose: AXI4-Lite slave holding two interpolator units
// Assumes: single clock aclk, synchronous active-low aresetn
// Notes: one write and one read in flight; reads answer one cycle after take, writes two cycles after
//
// Operation
// - two independent units, each own registers
// - combined result ready within one cycle
// - atomic add into selected lane accumulator
// - three writable readable addend registers
// - each lane accumulator writable and readable
// - raw read excludes first addend value
// - popping read reloads both accumulators, except one written in the same cycle
// - peek returns lane or full result
// - lane right-shifts accumulator before masking
// - mask keeps configured bit range only
// - signed option sign-extends masked value
// - force bits ORed into bus bits 29:28
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module ipd_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ipd_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ipd_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic is_writable(input logic [6:0] ofs);
    unique case (ofs)
      ipd_pkg::OFS_ACCUM0, ipd_pkg::OFS_ACCUM1, ipd_pkg::OFS_ADDEND0,
      ipd_pkg::OFS_ADDEND1, ipd_pkg::OFS_ADDEND2, ipd_pkg::OFS_CTRL0,
      ipd_pkg::OFS_CTRL1, ipd_pkg::OFS_ADD_ACC0, ipd_pkg::OFS_ADD_ACC1,
      ipd_pkg::OFS_ADDEND01: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : is_writable

  function automatic logic is_pop(input logic [6:0] ofs);
    return ofs == ipd_pkg::OFS_POP_LANE0 || ofs == ipd_pkg::OFS_POP_LANE1 ||
           ofs == ipd_pkg::OFS_POP_FULL;
  endfunction : is_pop

  function automatic logic [32:0] read_word(input ipd_pkg::ipd_view_t v,
                                            input logic [6:0] ofs);
    unique case (ofs)
      ipd_pkg::OFS_ACCUM0: return {1'b1, v.accum0};
      ipd_pkg::OFS_ACCUM1: return {1'b1, v.accum1};
      ipd_pkg::OFS_ADDEND0: return {1'b1, v.addend0};
      ipd_pkg::OFS_ADDEND1: return {1'b1, v.addend1};
      ipd_pkg::OFS_ADDEND2: return {1'b1, v.addend2};
      ipd_pkg::OFS_CTRL0: return {1'b1, v.ctrl0};
      ipd_pkg::OFS_CTRL1: return {1'b1, v.ctrl1};
      ipd_pkg::OFS_POP_LANE0, ipd_pkg::OFS_PEEK_LANE0: return {1'b1, v.peek0};
      ipd_pkg::OFS_POP_LANE1, ipd_pkg::OFS_PEEK_LANE1: return {1'b1, v.peek1};
      ipd_pkg::OFS_POP_FULL, ipd_pkg::OFS_PEEK_FULL,
      ipd_pkg::OFS_ADD_ACC0, ipd_pkg::OFS_ADD_ACC1: return {1'b1, v.full};
      ipd_pkg::OFS_RAW0: return {1'b1, v.raw0};
      ipd_pkg::OFS_RAW1: return {1'b1, v.raw1};
      default: return {1'b0, 32'h0000_0000};
    endcase
  endfunction : read_word

  // ****************************************
  // write channel
  // ****************************************
  logic aw_held_ff;
  logic w_held_ff;
  logic [ipd_pkg::ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic do_write;
  logic [6:0] wofs;

  assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wofs = awaddr_ff[6:0];

  // address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= '0;
      awready_ff <= 1'b0;
    end else if (s_axi_awvalid && awready_ff) begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
      awready_ff <= 1'b0;
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
    end else begin
      awready_ff <= !aw_held_ff && !bvalid_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      wready_ff <= 1'b0;
    end else if (s_axi_wvalid && wready_ff) begin
      w_held_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
      wready_ff <= 1'b0;
    end else if (do_write) begin
      w_held_ff <= 1'b0;
    end else begin
      wready_ff <= !w_held_ff && !bvalid_ff;
    end
  end

  // unmapped or read-only offsets answer slverr, nothing stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= ipd_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= is_writable(wofs) ? ipd_pkg::RESP_OKAY
                                    : ipd_pkg::RESP_SLVERR;
    end else if (s_axi_bready && bvalid_ff) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic rd_take;
  logic [6:0] rofs;
  logic rsel;
  logic [32:0] rword;
  ipd_pkg::ipd_view_t view [2];

  assign rd_take = s_axi_arvalid && arready_ff;
  assign rofs = s_axi_araddr[6:0];
  assign rsel = s_axi_araddr[ipd_pkg::UNIT_SEL_BIT];
  assign rword = read_word(view[rsel], rofs);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= ipd_pkg::RESP_OKAY;
    end else if (rd_take) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rword[31:0];
      rresp_ff <= rword[32] ? ipd_pkg::RESP_OKAY : ipd_pkg::RESP_SLVERR;
    end else if (s_axi_rready && rvalid_ff) begin
      rvalid_ff <= 1'b0;
    end else begin
      arready_ff <= !rvalid_ff;
    end
  end

  // ****************************************
  // units
  // ****************************************
  for (genvar u = 0; u < 2; u++) begin : g_unit
    ipd_pkg::ipd_wr_t wr;
    logic pop;
    assign wr.en = do_write && awaddr_ff[ipd_pkg::UNIT_SEL_BIT] == u[0];
    assign wr.ofs = wofs;
    assign wr.data = wdata_ff;
    assign wr.strb = wstrb_ff;
    assign pop = rd_take && rsel == u[0] && is_pop(rofs);
    ipd_unit u_unit (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr(wr),
      .pop(pop),
      .view(view[u])
    );
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

endmodule : ipd_top

// ==== ipd_pkg.sv ====
// Purpose: constants and carrier types of the interpolator datapath
// Assumes: 32-bit AXI4-Lite access, one aligned word per register
// Notes: register index is byte offset bits 6:2, unit select is bit 7
package ipd_pkg;

  // ****************************************
  // address map
  // ****************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned UNIT_SEL_BIT = 7;
  localparam logic [6:0] OFS_ACCUM0 = 7'h00;
  localparam logic [6:0] OFS_ACCUM1 = 7'h04;
  localparam logic [6:0] OFS_ADDEND0 = 7'h08;
  localparam logic [6:0] OFS_ADDEND1 = 7'h0C;
  localparam logic [6:0] OFS_ADDEND2 = 7'h10;
  localparam logic [6:0] OFS_POP_LANE0 = 7'h14;
  localparam logic [6:0] OFS_POP_LANE1 = 7'h18;
  localparam logic [6:0] OFS_POP_FULL = 7'h1C;
  localparam logic [6:0] OFS_PEEK_LANE0 = 7'h20;
  localparam logic [6:0] OFS_PEEK_LANE1 = 7'h24;
  localparam logic [6:0] OFS_PEEK_FULL = 7'h28;
  localparam logic [6:0] OFS_CTRL0 = 7'h2C;
  localparam logic [6:0] OFS_CTRL1 = 7'h30;
  localparam logic [6:0] OFS_ADD_ACC0 = 7'h34;
  localparam logic [6:0] OFS_ADD_ACC1 = 7'h38;
  localparam logic [6:0] OFS_ADDEND01 = 7'h3C;
  localparam logic [6:0] OFS_RAW0 = 7'h40;
  localparam logic [6:0] OFS_RAW1 = 7'h44;

  // ****************************************
  // lane control fields
  // ****************************************
  localparam int unsigned CTL_SHIFT_LSB = 0;
  localparam int unsigned CTL_MLSB_LSB = 5;
  localparam int unsigned CTL_MMSB_LSB = 10;
  localparam int unsigned CTL_SIGNED = 15;
  localparam int unsigned CTL_CROSS_IN = 16;
  localparam int unsigned CTL_CROSS_RES = 17;
  localparam int unsigned CTL_ADD_RAW = 18;
  localparam int unsigned CTL_FORCE_LSB = 19;
  localparam int unsigned CTL_USED_W = 21;
  localparam int unsigned FORCE_POS = 28;
  localparam logic [31:0] CTRL_RST = 32'h0000_7C00;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic en;
    logic [6:0] ofs;
    logic [31:0] data;
    logic [3:0] strb;
  } ipd_wr_t;

  typedef struct packed {
    logic [31:0] accum0;
    logic [31:0] accum1;
    logic [31:0] addend0;
    logic [31:0] addend1;
    logic [31:0] addend2;
    logic [31:0] ctrl0;
    logic [31:0] ctrl1;
    logic [31:0] peek0;
    logic [31:0] peek1;
    logic [31:0] full;
    logic [31:0] raw0;
    logic [31:0] raw1;
  } ipd_view_t;

endpackage : ipd_pkg

// ==== ipd_unit.sv ====
// Purpose: one interpolator unit, two lanes and three addend registers
// Assumes: writes and pops arrive as single-cycle pulses from the slave
// Notes: all results are combinational, valid in the same cycle
`timescale 1ns/1ps
module ipd_unit (
  input wire logic aclk,
  input wire logic aresetn,
  input wire ipd_pkg::ipd_wr_t wr,
  input wire logic pop,
  output ipd_pkg::ipd_view_t view
);

  logic [31:0] accum_ff [2];
  logic [31:0] addend_ff [3];
  logic [31:0] ctrl_ff [2];
  logic [31:0] sm [2];
  logic [31:0] res [2];
  logic [31:0] bus_res [2];

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // ****************************************
  // lane shift, mask, sign
  // ****************************************
  for (genvar i = 0; i < 2; i++) begin : g_lane
    logic [4:0] shamt;
    logic [4:0] mlsb;
    logic [4:0] mmsb;
    logic [31:0] src;
    logic [31:0] shifted;
    assign shamt = ctrl_ff[i][ipd_pkg::CTL_SHIFT_LSB +: 5];
    assign mlsb = ctrl_ff[i][ipd_pkg::CTL_MLSB_LSB +: 5];
    assign mmsb = ctrl_ff[i][ipd_pkg::CTL_MMSB_LSB +: 5];
    assign src = ctrl_ff[i][ipd_pkg::CTL_CROSS_IN] ? accum_ff[1-i]
                                                    : accum_ff[i];
    assign shifted = src >> shamt;
    always_comb begin
      sm[i] = 32'h0000_0000;
      for (int k = 0; k < 32; k++) begin
        if (k >= int'(mlsb) && k <= int'(mmsb)) begin
          sm[i][k] = shifted[k];
        end else if (k > int'(mmsb) && ctrl_ff[i][ipd_pkg::CTL_SIGNED]) begin
          sm[i][k] = shifted[mmsb];
        end
      end
    end
    assign bus_res[i] = res[i] |
      {2'b00, ctrl_ff[i][ipd_pkg::CTL_FORCE_LSB +: 2], 28'h000_0000};
  end

  // add_raw bypasses shift and mask for lane 0 only
  assign res[0] = addend_ff[0] + (ctrl_ff[0][ipd_pkg::CTL_ADD_RAW]
                                  ? accum_ff[0] : sm[0]);
  assign res[1] = addend_ff[1] + sm[1];

  // ****************************************
  // accumulators
  // ****************************************
  for (genvar i = 0; i < 2; i++) begin : g_acc
    logic [6:0] ofs_set;
    logic [6:0] ofs_add;
    assign ofs_set = (i == 0) ? ipd_pkg::OFS_ACCUM0 : ipd_pkg::OFS_ACCUM1;
    assign ofs_add = (i == 0) ? ipd_pkg::OFS_ADD_ACC0 : ipd_pkg::OFS_ADD_ACC1;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        accum_ff[i] <= ipd_pkg::DATA_RST;
      end else if (wr.en && wr.ofs == ofs_set) begin
        accum_ff[i] <= merge(accum_ff[i], wr.data, wr.strb);
      end else if (wr.en && wr.ofs == ofs_add) begin
        accum_ff[i] <= accum_ff[i] + wr.data;
      end else if (pop) begin
        accum_ff[i] <= ctrl_ff[i][ipd_pkg::CTL_CROSS_RES] ? res[1-i] : res[i];
      end
    end
  end

  // ****************************************
  // addends and lane control
  // ****************************************
  // three addend registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addend_ff[0] <= ipd_pkg::DATA_RST;
      addend_ff[1] <= ipd_pkg::DATA_RST;
      addend_ff[2] <= ipd_pkg::DATA_RST;
    end else if (wr.en) begin
      unique case (wr.ofs)
        ipd_pkg::OFS_ADDEND0: addend_ff[0] <= merge(addend_ff[0], wr.data,
                                                    wr.strb);
        ipd_pkg::OFS_ADDEND1: addend_ff[1] <= merge(addend_ff[1], wr.data,
                                                    wr.strb);
        ipd_pkg::OFS_ADDEND2: addend_ff[2] <= merge(addend_ff[2], wr.data,
                                                    wr.strb);
        ipd_pkg::OFS_ADDEND01: begin
          // halves sign-extend per lane signed option
          addend_ff[0] <= {{16{wr.data[15] & ctrl_ff[0][ipd_pkg::CTL_SIGNED]}},
                           wr.data[15:0]};
          addend_ff[1] <= {{16{wr.data[31] & ctrl_ff[1][ipd_pkg::CTL_SIGNED]}},
                           wr.data[31:16]};
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff[0] <= ipd_pkg::CTRL_RST;
      ctrl_ff[1] <= ipd_pkg::CTRL_RST;
    end else if (wr.en && wr.ofs == ipd_pkg::OFS_CTRL0) begin
      ctrl_ff[0] <= merge(ctrl_ff[0], wr.data, wr.strb) &
                    32'h001F_FFFF;
    end else if (wr.en && wr.ofs == ipd_pkg::OFS_CTRL1) begin
      ctrl_ff[1] <= merge(ctrl_ff[1], wr.data, wr.strb) &
                    32'h001F_FFFF;
    end
  end

  // ****************************************
  // observation
  // ****************************************
  // results ready same cycle
  assign view.accum0 = accum_ff[0];
  assign view.accum1 = accum_ff[1];
  assign view.addend0 = addend_ff[0];
  assign view.addend1 = addend_ff[1];
  assign view.addend2 = addend_ff[2];
  assign view.ctrl0 = ctrl_ff[0];
  assign view.ctrl1 = ctrl_ff[1];
  assign view.peek0 = bus_res[0];
  assign view.peek1 = bus_res[1];
  assign view.full = addend_ff[2] + sm[0] + sm[1];
  assign view.raw0 = sm[0];
  assign view.raw1 = sm[1];

endmodule : ipd_unit

// ==== ipd_chk.sv ====
// Purpose: bus protocol checker for the interpolator datapath
// Assumes: sees only the ports of ipd_top, one clock domain
// Notes: every property is off while aresetn is low
`timescale 1ns/1ps
module ipd_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ipd_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ipd_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_rd_done;
    s_axi_rvalid && s_axi_rready;
  endsequence
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_rd_answer;
    s_rd_take |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer late");
  property p_wr_answer;
    s_wr_take |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("write answer late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data not held");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write answer not held");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block)
    else $error("read taken while answer pending");
  property p_aw_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_block: assert property (p_aw_block)
    else $error("write taken while answer pending");
  property p_ready_back;
    s_rd_done |=> !s_axi_rvalid ##[0:1] s_axi_arready;
  endproperty
  a_ready_back: assert property (p_ready_back)
    else $error("read channel not reopened");
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[6:0] >= 7'h48 |=>
      s_axi_rresp == ipd_pkg::RESP_SLVERR && s_axi_rdata == ipd_pkg::DATA_RST;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");
endmodule : ipd_chk

bind ipd_top ipd_chk chk_u (.*);

// ==== ipd_host.sv ====
// Purpose: processor core model issuing single bus reads and writes
// Assumes: one transfer at a time, ready for answers after stall cycles
// Notes: released address and data lines show the inverse value
`timescale 1ns/1ps
module ipd_host (
  input wire logic aclk,
  output logic [ipd_pkg::ADDR_W-1:0] s_axi_awaddr,
  output logic [2:0] s_axi_awprot,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [ipd_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic [2:0] s_axi_arprot,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  int stall = 0;
  initial begin
    s_axi_awaddr = 8'h00;
    s_axi_awprot = 3'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arprot = 3'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end
  // ****************************************
  // transfers
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] r);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (s_axi_bvalid && s_axi_bready) break;
      // late ready keeps the answer standing
      if (k == stall) s_axi_bready <= 1'b1;
      k++;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (s_axi_rvalid && s_axi_rready) break;
      if (k == stall) s_axi_rready <= 1'b1;
      k++;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : ipd_host

// ==== interpolator_datapath_bench.sv ====
// Purpose: self-checking bench of the interpolator datapath
// Assumes: expected values worked by hand from the lane rules
// Notes: unit 0 lanes, unit 1 signed lane, refused accesses
`timescale 1ns/1ps
`define CHK(g, e) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module interpolator_datapath_bench;
  logic aclk;
  logic aresetn;
  logic [ipd_pkg::ADDR_W-1:0] s_axi_awaddr;
  logic [ipd_pkg::ADDR_W-1:0] s_axi_araddr;
  logic [2:0] s_axi_awprot;
  logic [2:0] s_axi_arprot;
  logic [31:0] s_axi_wdata;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp;
  logic [1:0] s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  ipd_top dut_u (.*);
  ipd_host host_u (.*);
  // ****************************************
  // tasks
  // ****************************************
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic wrc(input logic u, input logic [6:0] o,
    input logic [31:0] d, input logic [1:0] er = ipd_pkg::RESP_OKAY);
    logic [1:0] r;
    host_u.wr({u, o}, d, r);
    `CHK(r, er)
  endtask : wrc
  task automatic rdc(input logic u, input logic [6:0] o,
    input logic [31:0] e, input logic [1:0] er = ipd_pkg::RESP_OKAY);
    logic [31:0] d;
    logic [1:0] r;
    host_u.rd({u, o}, d, r);
    `CHK(d, e)
    `CHK(r, er)
  endtask : rdc
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // hang guard, tests need well under this
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      tally_and_finish();
    end
  end
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    aresetn = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(1'b0, ipd_pkg::OFS_CTRL0, ipd_pkg::CTRL_RST);
    rdc(1'b1, ipd_pkg::OFS_ACCUM1, ipd_pkg::DATA_RST);
    // shift 4, mask 7:0 on lane 0; mask 11:4 on lane 1
    wrc(1'b0, ipd_pkg::OFS_CTRL0, 32'h0000_1C04);
    wrc(1'b0, ipd_pkg::OFS_ACCUM0, 32'h0000_0ABC);
    rdc(1'b0, ipd_pkg::OFS_ACCUM0, 32'h0000_0ABC);
    wrc(1'b0, ipd_pkg::OFS_ADDEND0, 32'h0000_1000);
    rdc(1'b0, ipd_pkg::OFS_RAW0, 32'h0000_00AB);
    rdc(1'b0, ipd_pkg::OFS_PEEK_LANE0, 32'h0000_10AB);
    wrc(1'b0, ipd_pkg::OFS_CTRL1, 32'h0000_2C80);
    wrc(1'b0, ipd_pkg::OFS_ACCUM1, 32'hFFFF_F5A3);
    rdc(1'b0, ipd_pkg::OFS_RAW1, 32'h0000_05A0);
    wrc(1'b0, ipd_pkg::OFS_ADDEND1, 32'h0000_0010);
    wrc(1'b0, ipd_pkg::OFS_ADDEND2, 32'h0010_0000);
    rdc(1'b0, ipd_pkg::OFS_ADDEND2, 32'h0010_0000);
    rdc(1'b0, ipd_pkg::OFS_PEEK_FULL, 32'h0010_064B);
    rdc(1'b0, ipd_pkg::OFS_ACCUM0, 32'h0000_0ABC);
    host_u.stall = 3;
    rdc(1'b0, ipd_pkg::OFS_POP_LANE0, 32'h0000_10AB);
    rdc(1'b0, ipd_pkg::OFS_ACCUM0, 32'h0000_10AB);
    rdc(1'b0, ipd_pkg::OFS_ACCUM1, 32'h0000_05B0);
    rdc(1'b0, ipd_pkg::OFS_POP_FULL, 32'h0010_05BA);
    rdc(1'b0, ipd_pkg::OFS_ACCUM0, 32'h0000_100A);
    rdc(1'b0, ipd_pkg::OFS_ACCUM1, 32'h0000_05C0);
    wrc(1'b0, ipd_pkg::OFS_ADD_ACC1, 32'h0000_0020);
    host_u.stall = 0;
    rdc(1'b0, ipd_pkg::OFS_ACCUM1, 32'h0000_05E0);
    wrc(1'b0, ipd_pkg::OFS_ADD_ACC0, 32'hFFFF_FFFF);
    rdc(1'b0, ipd_pkg::OFS_ACCUM0, 32'h0000_1009);
    // unused control bits read as zero
    wrc(1'b0, ipd_pkg::OFS_CTRL0, 32'hFFFF_FFFF);
    rdc(1'b0, ipd_pkg::OFS_CTRL0, 32'h001F_FFFF);
    wrc(1'b0, ipd_pkg::OFS_CTRL0, 32'h0018_1C04);
    rdc(1'b0, ipd_pkg::OFS_PEEK_LANE0, 32'h3000_1000);
    rdc(1'b0, ipd_pkg::OFS_POP_LANE0, 32'h3000_1000);
    rdc(1'b0, ipd_pkg::OFS_ACCUM0, 32'h0000_1000);
    // second unit: signed lane 1, mask 7:0
    wrc(1'b1, ipd_pkg::OFS_CTRL1, 32'h0000_9C00);
    wrc(1'b1, ipd_pkg::OFS_ACCUM1, 32'h0000_0080);
    wrc(1'b1, ipd_pkg::OFS_ADDEND1, 32'h0000_0010);
    rdc(1'b1, ipd_pkg::OFS_RAW1, 32'hFFFF_FF80);
    rdc(1'b1, ipd_pkg::OFS_PEEK_LANE1, 32'hFFFF_FF90);
    rdc(1'b1, ipd_pkg::OFS_ADDEND0, ipd_pkg::DATA_RST);
    rdc(1'b0, ipd_pkg::OFS_CTRL1, 32'h0000_2C80);
    // refused accesses
    rdc(1'b0, 7'h48, ipd_pkg::DATA_RST, ipd_pkg::RESP_SLVERR);
    wrc(1'b1, 7'h48, 32'h0000_0001, ipd_pkg::RESP_SLVERR);
    wrc(1'b0, ipd_pkg::OFS_RAW0, 32'h0000_0001, ipd_pkg::RESP_SLVERR);
    rdc(1'b0, ipd_pkg::OFS_ACCUM0, 32'h0000_1000);
    tally_and_finish();
  end
endmodule : interpolator_datapath_bench
